// file: verilog/host_port_pkg.sv
// Constants and carrier types of the host control port
package host_port_pkg;

    // Interface mode strap codes
    localparam logic [1:0] MODE_SERIAL = 2'h0;
    localparam logic [1:0] MODE_LATCH  = 2'h1;
    localparam logic [1:0] MODE_STROBE = 2'h2;
    localparam logic [1:0] MODE_RESET  = 2'h3;

    // Serial frame: bit 0 read flag, bits 1-8 address, bits 9-16 data
    localparam logic [4:0] SER_RW_BIT   = 5'h00;
    localparam logic [4:0] SER_ADDR_END = 5'h08;
    localparam logic [4:0] SER_DATA_BEG = 5'h09;
    localparam logic [4:0] SER_DATA_END = 5'h10;
    localparam logic [4:0] SER_FRAME    = 5'h11;

    // Reset values
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic       TGL_RESET  = 1'h0;
    localparam logic       FLAG_RESET = 1'h0;
    localparam logic       HS_RESET   = 1'h1;
    localparam logic [4:0] CNT_RESET  = 5'h00;

    // Host parallel pins as seen after synchronising
    typedef struct packed {
        logic       cs_n;
        logic       ale;
        logic       address_strobe_n;
        logic       rd_n;
        logic       wr_n;
        logic       data_strobe_n;
        logic       rw;
        logic [7:0] ad;
    } par_pins_s;

    localparam par_pins_s PINS_RESET = '{cs_n: 1'h1, ale: 1'h0, address_strobe_n: 1'h1,
        rd_n: 1'h1, wr_n: 1'h1, data_strobe_n: 1'h1, rw: 1'h1, ad: 8'h00};

    // One register access towards the device core
    typedef struct packed {
        logic       valid;
        logic       write;
        logic [7:0] addr;
        logic [7:0] wdata;
    } core_req_s;

    localparam core_req_s REQ_RESET = '{valid: 1'h0, write: 1'h0, addr: 8'h00, wdata: 8'h00};

endpackage

// file: verilog/line_interface_host_port.sv
// Host control port: serial, latch-enable and data-strobe access to the core
`timescale 1ns/1ps
module line_interface_host_port (
    input  wire logic                     clk_sys,
    input  wire logic                     arst_n,
    input  wire logic [1:0]               mode_sel,
    input  wire logic                     cs_n,
    input  wire logic                     sclk,
    input  wire logic                     shift_edge_select,
    input  wire logic                     serial_in,
    output logic                          serial_out,
    input  wire logic                     ale,
    input  wire logic                     address_strobe_n,
    input  wire logic                     rd_n,
    input  wire logic                     wr_n,
    input  wire logic                     data_strobe_n,
    input  wire logic                     rw,
    input  wire logic [7:0]               ad_in,
    output logic [7:0]                    ad_out,
    output logic                          ad_oe_n,
    output logic                          ready,
    output logic                          ack_n,
    output host_port_pkg::core_req_s      core_req,
    input  wire logic [7:0]               core_rdata
);
    import host_port_pkg::*;

    typedef enum logic [1:0] {ST_IDLE, ST_ISSUE, ST_FETCH, ST_HOLD} acc_st_e;

    par_pins_s  pins_raw;
    par_pins_s  p1_q, p2_q, p3_q;
    logic [1:0] mode1_q, mode_q;
    logic       tg1_q, tg2_q, tg3_q, acc_wr_q;
    acc_st_e    st_q;
    core_req_s  core_req_q;
    logic [7:0] addr_q, rd_data_q;
    logic       ready_q, ack_n_q, ad_oe_n_q;
    logic       le_go, ds_go, ser_go, go, release_ok, drive;
    // Serial domain
    logic       srst_n, sclk_act;
    logic [4:0] cnt_q;
    logic [7:0] sh_q, s_addr_q, s_data_q;
    logic       s_rd_q, s_tgl_q, serial_out_q;
    logic [2:0] s_idx;

    // Outputs straight from flops
    assign serial_out = serial_out_q;
    assign ad_out     = rd_data_q;
    assign ad_oe_n    = ad_oe_n_q;
    assign ready      = ready_q;
    assign ack_n      = ack_n_q;
    assign core_req   = core_req_q;

    assign pins_raw = '{cs_n: cs_n, ale: ale, address_strobe_n: address_strobe_n, rd_n: rd_n,
        wr_n: wr_n, data_strobe_n: data_strobe_n, rw: rw, ad: ad_in};

    // Two-flop synchronisers plus history stage for edges
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            p1_q    <= PINS_RESET;
            p2_q    <= PINS_RESET;
            p3_q    <= PINS_RESET;
            mode1_q <= MODE_RESET;
            mode_q  <= MODE_RESET;
            tg1_q   <= TGL_RESET;
            tg2_q   <= TGL_RESET;
            tg3_q   <= TGL_RESET;
        end else begin
            p1_q    <= pins_raw;
            p2_q    <= p1_q;
            p3_q    <= p2_q;
            mode1_q <= mode_sel;
            mode_q  <= mode1_q;
            tg1_q   <= s_tgl_q;
            tg2_q   <= tg1_q;
            tg3_q   <= tg2_q;
        end
    end

    // Access start events; latch and strobe events gated by chip select, serial event not
    assign le_go  = (mode_q == MODE_LATCH) && !p2_q.cs_n && ((p3_q.rd_n && !p2_q.rd_n)
                    || (p3_q.wr_n && !p2_q.wr_n));
    assign ds_go  = (mode_q == MODE_STROBE) && !p2_q.cs_n && p3_q.data_strobe_n
                    && !p2_q.data_strobe_n;
    assign ser_go = (mode_q == MODE_SERIAL) && (tg2_q ^ tg3_q);
    assign go     = le_go || ds_go || ser_go;

    // Strobe release ends the hold phase
    always_comb begin
        release_ok = 1'b1;
        if (mode_q == MODE_LATCH) begin
            release_ok = p2_q.cs_n || (p2_q.rd_n && p2_q.wr_n);
        end else if (mode_q == MODE_STROBE) begin
            release_ok = p2_q.cs_n || p2_q.data_strobe_n;
        end
    end

    // Read data may be driven in this cycle
    always_comb begin
        drive = 1'b0;
        if (!acc_wr_q && !p2_q.cs_n && (st_q == ST_FETCH || st_q == ST_HOLD)) begin
            if (mode_q == MODE_LATCH) begin
                drive = !p2_q.rd_n;
            end else if (mode_q == MODE_STROBE) begin
                drive = p2_q.rw && !p2_q.data_strobe_n;
            end
        end
    end

    // Address phase of the multiplexed bus
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            addr_q <= BYTE_RESET;
        end else if (!p2_q.cs_n) begin
            if (mode_q == MODE_LATCH && p3_q.ale && !p2_q.ale) begin
                addr_q <= p2_q.ad;
            end else if (mode_q == MODE_STROBE && p3_q.address_strobe_n
                         && !p2_q.address_strobe_n) begin
                addr_q <= p2_q.ad;
            end
        end
    end

    // Access sequencer
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            st_q <= ST_IDLE;
        end else begin
            unique case (st_q)
                ST_IDLE:  if (go) st_q <= ST_ISSUE;
                ST_ISSUE: st_q <= ST_FETCH;
                ST_FETCH: st_q <= ST_HOLD;
                ST_HOLD:  if (release_ok) st_q <= ST_IDLE;
            endcase
        end
    end

    // Core request pulse; data phase follows the address
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            core_req_q <= REQ_RESET;
            acc_wr_q   <= FLAG_RESET;
        end else begin
            core_req_q.valid <= 1'b0;
            if (st_q == ST_IDLE && go) begin
                core_req_q.valid <= 1'b1;
                if (ser_go) begin
                    core_req_q.write <= !s_rd_q;
                    core_req_q.addr  <= s_addr_q;
                    core_req_q.wdata <= s_data_q;
                    acc_wr_q         <= !s_rd_q;
                end else begin
                    core_req_q.write <= le_go ? !p2_q.wr_n : !p2_q.rw;
                    core_req_q.addr  <= addr_q;
                    core_req_q.wdata <= p2_q.ad;
                    acc_wr_q         <= le_go ? !p2_q.wr_n : !p2_q.rw;
                end
            end
        end
    end

    // Read data captured one cycle after the request
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rd_data_q <= BYTE_RESET;
        end else if (st_q == ST_FETCH && !acc_wr_q) begin
            rd_data_q <= core_rdata;
        end
    end

    // Handshake outputs of the parallel modes
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ready_q   <= HS_RESET;
            ack_n_q   <= HS_RESET;
            ad_oe_n_q <= HS_RESET;
        end else begin
            ready_q   <= !((st_q == ST_IDLE && le_go) || st_q == ST_ISSUE);
            ack_n_q   <= !(mode_q == MODE_STROBE && (st_q == ST_FETCH
                         || (st_q == ST_HOLD && !release_ok)));
            ad_oe_n_q <= !drive;
        end
    end

    // Serial side: chip select high clears the frame
    assign srst_n   = arst_n && !cs_n;
    assign sclk_act = sclk ^ shift_edge_select;
    assign s_idx    = 3'(SER_DATA_END - cnt_q);

    // Bit counter and input shifter on rising shift clock
    always_ff @(posedge sclk or negedge srst_n) begin
        if (!srst_n) begin
            cnt_q <= CNT_RESET;
            sh_q  <= BYTE_RESET;
        end else begin
            sh_q <= {sh_q[6:0], serial_in};
            if (cnt_q != SER_FRAME) cnt_q <= cnt_q + 5'h01;
        end
    end

    // Captured frame fields survive chip select release
    always_ff @(posedge sclk or negedge arst_n) begin
        if (!arst_n) begin
            s_rd_q   <= FLAG_RESET;
            s_tgl_q  <= TGL_RESET;
            s_addr_q <= BYTE_RESET;
            s_data_q <= BYTE_RESET;
        end else if (!cs_n) begin
            if (cnt_q == SER_RW_BIT) s_rd_q <= serial_in;
            if (cnt_q == SER_ADDR_END) begin
                s_addr_q <= {sh_q[6:0], serial_in};
                if (s_rd_q) s_tgl_q <= !s_tgl_q;
            end
            if (cnt_q == SER_DATA_END && !s_rd_q) begin
                s_data_q <= {sh_q[6:0], serial_in};
                s_tgl_q  <= !s_tgl_q;
            end
        end
    end

    // Read data shifted out MSB first on the selected edge
    always_ff @(posedge sclk_act or negedge srst_n) begin
        if (!srst_n) begin
            serial_out_q <= FLAG_RESET;
        end else if (cnt_q >= SER_DATA_BEG && cnt_q <= SER_DATA_END) begin
            serial_out_q <= rd_data_q[s_idx];
        end
    end

    // Checks on the system clock
    property p_ack_read;
        @(posedge clk_sys) disable iff (!arst_n)
        $fell(ack_n_q) && !acc_wr_q && p2_q.rw |-> !ad_oe_n_q && ad_out == $past(core_rdata);
    endproperty
    a_ack_read: assert property (p_ack_read) else $error("ack without read data");
    property p_ack_write;
        @(posedge clk_sys) disable iff (!arst_n)
        $fell(ack_n_q) && acc_wr_q |-> $past(core_req_q.valid && core_req_q.write, 2);
    endproperty
    a_ack_write: assert property (p_ack_write) else $error("ack before write");
    property p_ready_busy;
        @(posedge clk_sys) disable iff (!arst_n)
        le_go && st_q == ST_IDLE |=> !ready_q ##1 !ready_q ##1 ready_q;
    endproperty
    a_ready_busy: assert property (p_ready_busy) else $error("ready timing wrong");
    property p_le_drive;
        @(posedge clk_sys) disable iff (!arst_n)
        mode_q == MODE_LATCH && !ad_oe_n_q |-> !$past(p2_q.rd_n) && !$past(p2_q.cs_n);
    endproperty
    a_le_drive: assert property (p_le_drive) else $error("bus driven without read");
    property p_ds_drive;
        @(posedge clk_sys) disable iff (!arst_n)
        mode_q == MODE_STROBE && !ad_oe_n_q |-> $past(p2_q.rw) && !$past(p2_q.data_strobe_n);
    endproperty
    a_ds_drive: assert property (p_ds_drive) else $error("bus driven on write");
    property p_addr_latch;
        @(posedge clk_sys) disable iff (!arst_n)
        mode_q == MODE_LATCH && !p2_q.cs_n && $fell(p2_q.ale) |=> addr_q == $past(p2_q.ad);
    endproperty
    a_addr_latch: assert property (p_addr_latch) else $error("address not latched");
    property p_par_addr;
        @(posedge clk_sys) disable iff (!arst_n)
        (le_go || ds_go) && st_q == ST_IDLE |=> core_req_q.valid && core_req_q.addr == $past(addr_q);
    endproperty
    a_par_addr: assert property (p_par_addr) else $error("wrong access address");
    // Checks on the shift clock
    property p_sin_shift;
        @(posedge sclk) disable iff (!srst_n)
        cnt_q != 5'h00 |-> sh_q[0] == $past(serial_in);
    endproperty
    a_sin_shift: assert property (p_sin_shift) else $error("serial input missed");
    property p_sout_phase;
        @(posedge sclk_act) disable iff (!srst_n)
        $changed(serial_out_q) |-> $past(cnt_q) >= SER_DATA_BEG;
    endproperty
    a_sout_phase: assert property (p_sout_phase) else $error("serial out moved early");
    c_ser_read:  cover property (@(posedge clk_sys) disable iff (!arst_n)
        ser_go && s_rd_q ##3 st_q == ST_HOLD);
    c_le_write:  cover property (@(posedge clk_sys) disable iff (!arst_n)
        le_go && !p2_q.wr_n ##3 ready_q);
    c_ds_read:   cover property (@(posedge clk_sys) disable iff (!arst_n)
        $fell(ack_n_q) && !ad_oe_n_q);
endmodule

// file: testbench/host_model.sv
// Host microcontroller model driving the serial and parallel access pins
`timescale 1ns/1ps
module host_model (
    input  wire logic       clk_sys,
    input  wire logic       shift_edge_select,
    input  wire logic       serial_out,
    input  wire logic [7:0] ad_out,
    input  wire logic       ad_oe_n,
    input  wire logic       ready,
    input  wire logic       ack_n,
    output logic            cs_n,
    output logic            sclk,
    output logic            serial_in,
    output logic            ale,
    output logic            address_strobe_n,
    output logic            rd_n,
    output logic            wr_n,
    output logic            data_strobe_n,
    output logic            rw,
    output logic [7:0]      ad_in
);
    logic       hoe;
    logic [7:0] ad_h;

    // Pins at rest; shift clock stands still between frames
    initial begin
        {cs_n, address_strobe_n, rd_n, wr_n, data_strobe_n, rw, hoe} = 7'h7f;
        {sclk, serial_in, ale} = 3'h0;
        ad_h = 8'h00;
    end

    // Bus level; a released undriven bus shows the inverted last value
    assign ad_in = !ad_oe_n ? ad_out : (hoe ? ad_h : ~ad_h);

    // Serial frame of n bits, MSB first, sampled opposite the active edge
    task automatic ser(input logic [16:0] f, input int n, output logic [7:0] rd);
        rd = 8'h00;
        @(posedge clk_sys) cs_n <= 1'b0;
        #7;
        for (int i = 0; i < n; i++) begin
            serial_in = f[16-i];
            #3;
            if (shift_edge_select && i >= 9) rd = {rd[6:0], serial_out};
            sclk = 1'b1;
            // Turnaround pause right after the last address bit, before any further edge
            if (i == 8) #150;
            #3;
            if (!shift_edge_select && i >= 9) rd = {rd[6:0], serial_out};
            sclk = 1'b0;
        end
        #3;
        @(posedge clk_sys) cs_n <= 1'b1;
        repeat (13) @(posedge clk_sys);
    endtask

    // One parallel access; m selects data-strobe mode, else latch mode
    task automatic par(input logic m, wr, input logic [7:0] a, d,
                       output logic [7:0] rd, output logic ok);
        int   n;
        logic lo;
        n = 0;
        lo = 1'b0;
        @(posedge clk_sys);
        cs_n <= 1'b0;
        ad_h <= a;
        rw   <= !wr;
        ale  <= !m;
        repeat (3) @(posedge clk_sys);
        ale              <= 1'b0;
        address_strobe_n <= !m;
        repeat (4) @(posedge clk_sys);
        hoe  <= wr;
        ad_h <= d;
        if (m) data_strobe_n <= 1'b0;
        else if (wr) wr_n <= 1'b0;
        else rd_n <= 1'b0;
        do begin
            @(negedge clk_sys);
            n++;
            lo |= (ready === 1'b0);
        end while (!(m ? ack_n === 1'b0 : (lo && ready === 1'b1)) && n < 12);
        ok = (n < 12) && (m || lo) && (ad_oe_n === wr);
        rd = ad_in;
        repeat (2) @(negedge clk_sys);
        ok &= (m ? ack_n === 1'b0 : ready === 1'b1) && (ad_oe_n === wr);
        @(posedge clk_sys);
        {rd_n, wr_n, data_strobe_n} <= 3'h7;
        repeat (4) @(negedge clk_sys);
        ok &= (ad_oe_n === 1'b1) && (ack_n === 1'b1) && (ready === 1'b1);
        @(posedge clk_sys);
        {cs_n, address_strobe_n, hoe} <= 3'h7;
        repeat (3) @(posedge clk_sys);
    endtask
endmodule

// file: testbench/test_line_interface_host_port.sv
// Self-checking bench of the host control port
`timescale 1ns/1ps
module test_line_interface_host_port;
    import host_port_pkg::*;
    logic        clk_sys = 1'b0;
    logic        arst_n, shift_edge_select, cs_n, sclk, serial_in, serial_out, ale;
    logic        address_strobe_n, rd_n, wr_n, data_strobe_n, rw, ad_oe_n, ready, ack_n;
    logic [1:0]  mode_sel;
    logic [7:0]  ad_in, ad_out, core_rdata, a, d, rd;
    core_req_s   core_req;
    logic        ok;
    logic [31:0] seed = 32'h0000_e164;
    logic [16:0] exp_q[$];
    int          err_count = 0;
    int          compares = 0;

    // System clock
    always #5 clk_sys = ~clk_sys;

    line_interface_host_port u_line_interface_host_port (
        .clk_sys(clk_sys), .arst_n(arst_n), .mode_sel(mode_sel), .cs_n(cs_n), .sclk(sclk),
        .shift_edge_select(shift_edge_select), .serial_in(serial_in),
        .serial_out(serial_out), .ale(ale), .address_strobe_n(address_strobe_n),
        .rd_n(rd_n), .wr_n(wr_n), .data_strobe_n(data_strobe_n), .rw(rw), .ad_in(ad_in),
        .ad_out(ad_out), .ad_oe_n(ad_oe_n), .ready(ready), .ack_n(ack_n),
        .core_req(core_req), .core_rdata(core_rdata));

    host_model u_host_model (
        .clk_sys(clk_sys), .shift_edge_select(shift_edge_select), .serial_out(serial_out),
        .ad_out(ad_out), .ad_oe_n(ad_oe_n), .ready(ready), .ack_n(ack_n), .cs_n(cs_n),
        .sclk(sclk), .serial_in(serial_in), .ale(ale), .address_strobe_n(address_strobe_n),
        .rd_n(rd_n), .wr_n(wr_n), .data_strobe_n(data_strobe_n), .rw(rw), .ad_in(ad_in));

    // Xorshift source for addresses and data
    function automatic logic [7:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction

    // Compare and count
    task automatic check(input string nm, input logic [16:0] e, g);
        compares++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Counts and verdict
    task automatic summarize();
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // Core model and access monitor; read data is address xor a mask
    always @(posedge clk_sys) begin
        if (core_req.valid === 1'b1) begin
            core_rdata <= core_req.addr ^ 8'h3c;
            if (exp_q.size() == 0) check("unexpected access", 17'h0_0000, 17'h1_ffff);
            else check("core access", exp_q.pop_front(),
                {core_req.write, core_req.addr, core_req.write ? core_req.wdata : 8'h00});
        end
    end

    // Hang guard
    initial begin
        #100_000;
        err_count++;
        $display("watchdog expired");
        summarize();
    end

    // Main sequence
    initial begin
        arst_n = 1'b0;
        mode_sel = MODE_RESET;
        shift_edge_select = 1'b0;
        core_rdata = 8'h00;
        repeat (12) @(posedge clk_sys);
        arst_n <= 1'b1;
        @(negedge clk_sys);
        check("idle outputs", 17'h0_0007, {14'h0, ready, ack_n, ad_oe_n});
        @(posedge clk_sys);
        for (int m = 0; m < 2; m++) begin
            mode_sel <= m ? MODE_STROBE : MODE_LATCH;
            repeat (4) @(posedge clk_sys);
            for (int k = 0; k < 4; k++) begin
                a = xs();
                d = xs();
                exp_q.push_back({!k[0], a, k[0] ? 8'h00 : d});
                u_host_model.par(m[0], !k[0], a, d, rd, ok);
                check("handshake", 17'h0_0001, {16'h0, ok});
                if (k[0]) check("parallel read", {9'h0, a ^ 8'h3c}, {9'h0, rd});
            end
            $display("parallel mode %0d done", m);
        end
        mode_sel <= MODE_SERIAL;
        for (int s = 0; s < 2; s++) begin
            shift_edge_select <= s[0];
            repeat (4) @(posedge clk_sys);
            a = xs();
            d = xs();
            exp_q.push_back({1'b1, a, d});
            u_host_model.ser({1'b0, a, d}, 17, rd);
            exp_q.push_back({1'b0, a, 8'h00});
            u_host_model.ser({1'b1, a, 8'h00}, 17, rd);
            check("serial read", {9'h0, a ^ 8'h3c}, {9'h0, rd});
            u_host_model.ser({1'b0, a, d}, 5, rd);
            $display("serial edge select %0d done", s);
        end
        repeat (20) @(posedge clk_sys);
        check("pending accesses", 17'h0_0000, 17'(exp_q.size()));
        summarize();
    end
endmodule
